// >>> hw/bfws_pkg.sv
// Package for the bus fault and wake status register group
`default_nettype none
package bfws_pkg;
    localparam logic [6:0] ADDR_BUS_FAULT_A = 7'h44;
    localparam logic [6:0] ADDR_BUS_FAULT_B = 7'h45;
    localparam logic [6:0] ADDR_WAKE_A = 7'h46;
    localparam logic [6:0] ADDR_WAKE_B = 7'h47;
    localparam logic [6:0] ADDR_LEVEL = 7'h48;
    localparam logic [7:0] RESET_STATUS = 8'h00;
    // Field positions
    localparam int LIN1_LSB = 5;
    localparam int CAN_LSB = 1;
    localparam int CANUV_BIT = 0;
    localparam int LIN2_LSB = 1;
    localparam int REGMODE_BIT = 7;
    localparam int CANWK_BIT = 5;
    localparam int TMRWK_BIT = 4;
    localparam int HVWK_BIT = 0;
    localparam int LIN2WK_BIT = 1;
    localparam int LIN1WK_BIT = 0;
    localparam int DEVPIN_BIT = 7;
    localparam int ONE_BIT = 6;
    localparam int CFG_BIT = 5;
    localparam int HVLVL_BIT = 0;
    // Transmitter enable time
    localparam int TX_EN_TIME_NS = 8000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TX_EN_CYCLES = (TX_EN_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        FAULT_NONE = 2'h0,
        FAULT_THERMAL = 2'h1,
        FAULT_TXD_STUCK = 2'h2,
        FAULT_BUS_STUCK = 2'h3
    } bfws_fault_t;
    // Condition inputs from one transceiver
    typedef struct packed {
        logic thermal;
        logic txd_timeout;
        logic bus_timeout;
        logic txd_high;
        logic bus_recessive;
        logic wake_or_off;
    } bfws_xcvr_t;
    typedef enum logic [1:0] {
        CAN_OFF = 2'h0,
        CAN_NORMAL = 2'h1,
        CAN_RX_ONLY = 2'h3,
        CAN_WAKE = 2'h2
    } bfws_can_mode_t;
endpackage : bfws_pkg
`default_nettype wire

// >>> hw/bfws_status.sv
// Bus fault and wake status register group with transmitter gating
// Contract
// - First LIN fault code at bits 6:5: none, thermal, txd stuck, bus stuck.
// - CAN fault code at bits 2:1 with same encoding.
// - CAN supply undervoltage sets bit 0 and disables CAN transmitter.
// - Reserved bits read zero, except the one reading one.
// - Txd stuck ends when txd high, or wake-capable or off; code also ends it on bus recessive.
// - Bus stuck ends when bus recessive, or wake-capable or off; code also ends it on txd high.
// - Supply undervoltage ends once supply back above threshold.
// - After recovery transmit resumes only after txd high for enable time.
// - CAN undervoltage monitor active in normal, rx-only, or wake after WUP.
// - Second LIN fault code at bits 2:1 of register 0x45.
// - Wake register 0x46: CAN bit 5, timer bit 4, hv input bit 0.
// - Wake register 0x47: second LIN bit 1, first LIN bit 0.
// - Bit 7 of 0x46 set on regulator automatic mode change.
// - Development pin level at bit 7 of level register.
// - Level register bit 6 always reads one.
// - Level register bit 5 mirrors the fail output configuration bit.
// - High-voltage wake input level at bit 0 of register 0x48.
// - Status registers clear on reset; second LIN code kept on restart.
// - First bus status register sits at address 0x44.
`default_nettype none
module bfws_status #(
    parameter int TX_EN_CYC = bfws_pkg::TX_EN_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_restart,
    // Register access
    input wire logic [6:0] i_addr,
    input wire logic i_rd,
    input wire logic i_clr,
    output logic [7:0] o_rdata,
    // Transceiver conditions
    input wire bfws_pkg::bfws_xcvr_t i_can,
    input wire bfws_pkg::bfws_xcvr_t i_lin1,
    input wire bfws_pkg::bfws_xcvr_t i_lin2,
    input wire bfws_pkg::bfws_can_mode_t i_can_mode,
    input wire logic i_can_wup_seen,
    input wire logic i_can_supply_low,
    // Wake events
    input wire logic i_can_wake,
    input wire logic i_timer_wake,
    input wire logic i_hv_wake,
    input wire logic i_lin1_wake,
    input wire logic i_lin2_wake,
    input wire logic i_regulator_mode_change,
    // Pin levels and configuration
    input wire logic i_dev_mode_pin,
    input wire logic i_hv_wake_input,
    input wire logic i_fail_output_config_bit,
    // Transmitter enables and flags
    output logic o_can_tx_en,
    output logic o_lin1_tx_en,
    output logic o_lin2_tx_en,
    output logic o_thermal_shutdown_one_flag
);
    localparam int CW = $clog2(TX_EN_CYC + 1);
    // Pin synchronisers, status flags and transmitter gating state
    logic [1:0] s1_reg, s1_next, s2_reg, s2_next;
    logic [1:0] bfa_lin1_reg, bfa_lin1_next, bfa_can_reg, bfa_can_next;
    logic canuv_reg, canuv_next, lin2_rst_hold;
    logic [1:0] lin2_reg, lin2_next;
    logic [7:0] wka_reg, wka_next, wkb_reg, wkb_next;
    logic [7:0] rdata_reg, rdata_next;
    logic tsd_reg, tsd_next;
    logic [2:0] act_reg, act_next;
    logic [CW-1:0] cnt_reg [3];
    logic [CW-1:0] cnt_next [3];
    logic [2:0] en_reg, en_next;
    logic uv_mon;
    bfws_pkg::bfws_xcvr_t x [3];
    logic [2:0] clr_hit, ok;
    logic [7:0] bfa, bfb, lvl;

    assign x[0] = i_can;
    assign x[1] = i_lin1;
    assign x[2] = i_lin2;
    assign lin2_rst_hold = i_restart;

    function automatic logic [1:0] fault_code(
        input bfws_pkg::bfws_xcvr_t c,
        input logic [1:0] cur
    );
        logic [1:0] r;
        r = cur;
        if (c.thermal) begin
            r = bfws_pkg::FAULT_THERMAL;
        end else if (c.bus_timeout) begin
            r = bfws_pkg::FAULT_BUS_STUCK;
        end else if (c.txd_timeout) begin
            r = bfws_pkg::FAULT_TXD_STUCK;
        end
        return r;
    endfunction : fault_code

    always_comb begin
        uv_mon = (i_can_mode == bfws_pkg::CAN_NORMAL)
            || (i_can_mode == bfws_pkg::CAN_RX_ONLY)
            || (i_can_mode == bfws_pkg::CAN_WAKE && i_can_wup_seen);
        s1_next = {i_dev_mode_pin, i_hv_wake_input};
        s2_next = s1_reg;
        clr_hit[0] = i_clr && i_addr == bfws_pkg::ADDR_BUS_FAULT_A;
        clr_hit[1] = i_clr && i_addr == bfws_pkg::ADDR_BUS_FAULT_B;
        clr_hit[2] = i_clr && (i_addr == bfws_pkg::ADDR_WAKE_A
            || i_addr == bfws_pkg::ADDR_WAKE_B);
        // Set wins over clear; flags hold until cleared
        bfa_lin1_next = fault_code(i_lin1, clr_hit[0] ? 2'h0 : bfa_lin1_reg);
        bfa_can_next = fault_code(i_can, clr_hit[0] ? 2'h0 : bfa_can_reg);
        canuv_next = (uv_mon && i_can_supply_low) || (!clr_hit[0] && canuv_reg);
        lin2_next = fault_code(i_lin2, clr_hit[1] ? 2'h0 : lin2_reg);
        tsd_next = i_can.thermal || i_lin1.thermal || i_lin2.thermal
            || tsd_reg;
        wka_next = clr_hit[2] && i_addr == bfws_pkg::ADDR_WAKE_A
            ? 8'h00 : wka_reg;
        wkb_next = clr_hit[2] && i_addr == bfws_pkg::ADDR_WAKE_B
            ? 8'h00 : wkb_reg;
        wka_next[bfws_pkg::REGMODE_BIT] = wka_next[bfws_pkg::REGMODE_BIT]
            | i_regulator_mode_change;
        wka_next[bfws_pkg::CANWK_BIT] = wka_next[bfws_pkg::CANWK_BIT]
            | i_can_wake;
        wka_next[bfws_pkg::TMRWK_BIT] = wka_next[bfws_pkg::TMRWK_BIT]
            | i_timer_wake;
        wka_next[bfws_pkg::HVWK_BIT] = wka_next[bfws_pkg::HVWK_BIT]
            | i_hv_wake;
        wkb_next[bfws_pkg::LIN2WK_BIT] = wkb_next[bfws_pkg::LIN2WK_BIT]
            | i_lin2_wake;
        wkb_next[bfws_pkg::LIN1WK_BIT] = wkb_next[bfws_pkg::LIN1WK_BIT]
            | i_lin1_wake;
        bfa = 8'h00;
        bfa[bfws_pkg::LIN1_LSB +: 2] = bfa_lin1_reg;
        bfa[bfws_pkg::CAN_LSB +: 2] = bfa_can_reg;
        bfa[bfws_pkg::CANUV_BIT] = canuv_reg;
        bfb = 8'h00;
        bfb[bfws_pkg::LIN2_LSB +: 2] = lin2_reg;
        lvl = 8'h00;
        lvl[bfws_pkg::DEVPIN_BIT] = s2_reg[1];
        lvl[bfws_pkg::ONE_BIT] = 1'b1;
        lvl[bfws_pkg::CFG_BIT] = i_fail_output_config_bit;
        lvl[bfws_pkg::HVLVL_BIT] = s2_reg[0];
        rdata_next = rdata_reg;
        if (i_rd) begin
            case (i_addr)
                bfws_pkg::ADDR_BUS_FAULT_A: rdata_next = bfa;
                bfws_pkg::ADDR_BUS_FAULT_B: rdata_next = bfb;
                bfws_pkg::ADDR_WAKE_A: rdata_next = wka_reg & 8'hB1;
                bfws_pkg::ADDR_WAKE_B: rdata_next = wkb_reg & 8'h03;
                bfws_pkg::ADDR_LEVEL: rdata_next = lvl;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Live fault tracking and transmitter re-enable per transceiver
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            act_next[i] = act_reg[i];
            if (x[i].thermal || x[i].txd_timeout || x[i].bus_timeout) begin
                act_next[i] = 1'b1;
            end else if (x[i].wake_or_off
                || x[i].txd_high || x[i].bus_recessive) begin
                act_next[i] = 1'b0;
            end
            // Enable drops the cycle after any fault shows, not after latch
            ok[i] = !act_reg[i] && !x[i].thermal
                && !x[i].txd_timeout && !x[i].bus_timeout;
            if (i == 0) begin
                ok[i] = ok[i] && !(uv_mon && i_can_supply_low);
            end
            cnt_next[i] = cnt_reg[i];
            en_next[i] = en_reg[i];
            if (!ok[i] || !x[i].txd_high) begin
                cnt_next[i] = '0;
                if (!ok[i]) begin
                    en_next[i] = 1'b0;
                end
            end else if (!en_reg[i]) begin
                if (cnt_reg[i] >= CW'(TX_EN_CYC - 1)) begin
                    en_next[i] = 1'b1;
                end else begin
                    cnt_next[i] = cnt_reg[i] + CW'(1);
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        s1_reg <= s1_next;
        s2_reg <= s2_next;
        if (!i_rstn) begin
            bfa_lin1_reg <= bfws_pkg::RESET_STATUS[1:0];
            bfa_can_reg <= bfws_pkg::RESET_STATUS[1:0];
            canuv_reg <= 1'b0;
            wka_reg <= bfws_pkg::RESET_STATUS;
            wkb_reg <= bfws_pkg::RESET_STATUS;
            tsd_reg <= 1'b0;
            rdata_reg <= 8'h00;
            act_reg <= 3'h0;
            en_reg <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                cnt_reg[i] <= '0;
            end
        end else begin
            bfa_lin1_reg <= bfa_lin1_next;
            bfa_can_reg <= bfa_can_next;
            canuv_reg <= canuv_next;
            wka_reg <= wka_next;
            wkb_reg <= wkb_next;
            tsd_reg <= tsd_next;
            rdata_reg <= rdata_next;
            act_reg <= act_next;
            en_reg <= en_next;
            cnt_reg <= cnt_next;
        end
        // Second LIN code survives a restart reset
        if (!i_rstn && !lin2_rst_hold) begin
            lin2_reg <= 2'h0;
        end else if (i_rstn) begin
            lin2_reg <= lin2_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_can_tx_en = en_reg[0];
    assign o_lin1_tx_en = en_reg[1];
    assign o_lin2_tx_en = en_reg[2];
    assign o_thermal_shutdown_one_flag = tsd_reg;
endmodule : bfws_status
`default_nettype wire

// >>> verification/bfws_host.sv
// Host model issuing register reads and clears
`default_nettype none
module bfws_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [6:0] o_addr,
    output logic o_rd,
    output logic o_clr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_addr = 7'h00;
        o_rd = 1'b0;
        o_clr = 1'b0;
    end
    task automatic access(input logic [6:0] a, input logic c,
                          output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= !c;
        o_clr <= c;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_clr <= 1'b0;
        // Stale address is not left on the lines
        o_addr <= ~a;
        @(negedge i_clk);
        d = i_rdata;
    endtask : access
endmodule : bfws_host
`default_nettype wire

// >>> verification/bfws_status_asserts.sv
// Concurrent checks on the status block ports
`default_nettype none
module bfws_status_asserts #(
    parameter int TX_EN_CYC = 4
) (
    input wire logic i_clk, i_rstn, i_rd, i_clr,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] o_rdata,
    input wire bfws_pkg::bfws_xcvr_t i_can, i_lin1,
    input wire bfws_pkg::bfws_can_mode_t i_can_mode,
    input wire logic i_can_supply_low, i_can_wake,
    input wire logic i_fail_output_config_bit,
    input wire logic o_can_tx_en, o_lin1_tx_en,
    input wire logic o_thermal_shutdown_one_flag
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence rd_of(logic [6:0] a);
        !i_clr ##1 i_rd && !i_clr && i_addr == a;
    endsequence
    rd_unmapped_a: assert property (i_rd && (i_addr < 7'h44 ||
        i_addr > 7'h48) |=> o_rdata == 8'h00) else $error("bad unmapped");
    busa_rsvd_a: assert property (i_rd && i_addr == 7'h44 |=>
        o_rdata[7] == 1'b0 && o_rdata[4:3] == 2'h0) else $error("rsvd A");
    busb_rsvd_a: assert property (i_rd && i_addr == 7'h45 |=>
        o_rdata[7:3] == 5'h00 && !o_rdata[0]) else $error("rsvd B");
    lvl_one_a: assert property (i_rd && i_addr == 7'h48 |=>
        o_rdata[6]) else $error("level bit 6 low");
    cfg_mirror_a: assert property (i_rd && i_addr == 7'h48 |=>
        o_rdata[5] == $past(i_fail_output_config_bit)) else $error("cfg");
    uv_tx_off_a: assert property (i_can_supply_low &&
        i_can_mode == bfws_pkg::CAN_NORMAL |=> !o_can_tx_en) else $error("uv");
    thermal_tx_off_a: assert property (i_can.thermal |=>
        !o_can_tx_en && o_thermal_shutdown_one_flag) else $error("tsd");
    tx_resume_a: assert property ($rose(o_lin1_tx_en) |->
        $past(i_lin1.txd_high)) else $error("early enable");
    lin1_code_a: assert property (i_lin1.thermal ##1
        rd_of(7'h44) |=> o_rdata[6:5] == 2'h1) else $error("lin1 code");
    can_wake_a: assert property (i_can_wake ##1
        rd_of(7'h46) |=> o_rdata[5]) else $error("can wake lost");
endmodule : bfws_status_asserts
bind bfws_status bfws_status_asserts #(.TX_EN_CYC(TX_EN_CYC)) u_chk (
    .i_clk, .i_rstn, .i_rd, .i_clr, .i_addr, .o_rdata, .i_can, .i_lin1,
    .i_can_mode, .i_can_supply_low, .i_can_wake, .i_fail_output_config_bit,
    .o_can_tx_en, .o_lin1_tx_en, .o_thermal_shutdown_one_flag);
`default_nettype wire

// >>> verification/bfws_status_tb_top.sv
// Testbench for the bus fault and wake status block
`default_nettype none
module bfws_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam bfws_pkg::bfws_xcvr_t OK = 6'h06;
    logic i_clk, i_rstn, rst_kind, rd, clr, wup, uv, dev, hvl, cfg;
    logic can_en, l1_en, l2_en, tsd;
    logic [5:0] wk;
    logic [6:0] addr;
    logic [7:0] rdata, d;
    bfws_pkg::bfws_xcvr_t can, lin1, lin2, f;
    bfws_pkg::bfws_can_mode_t mode;
    int mismatches, compares, cyc;
    bfws_status #(.TX_EN_CYC(4)) u_bfws_status (.i_clk(i_clk),
        .i_rstn(i_rstn), .i_restart(rst_kind), .i_addr(addr), .i_rd(rd),
        .i_clr(clr), .o_rdata(rdata), .i_can(can), .i_lin1(lin1),
        .i_lin2(lin2), .i_can_mode(mode), .i_can_wup_seen(wup),
        .i_can_supply_low(uv), .i_can_wake(wk[0]), .i_timer_wake(wk[1]),
        .i_hv_wake(wk[2]), .i_lin1_wake(wk[3]), .i_lin2_wake(wk[4]),
        .i_regulator_mode_change(wk[5]), .i_dev_mode_pin(dev),
        .i_hv_wake_input(hvl), .i_fail_output_config_bit(cfg),
        .o_can_tx_en(can_en), .o_lin1_tx_en(l1_en), .o_lin2_tx_en(l2_en),
        .o_thermal_shutdown_one_flag(tsd));
    bfws_host u_bfws_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
        .o_rd(rd), .o_clr(clr));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
        end
    endtask : chk
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        u_bfws_host.access(a, 1'b0, d);
        chk(d, e);
    endtask : rdc
    task automatic close_out;
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        {i_rstn, rst_kind, wup, uv, dev, hvl, cfg, wk} = 13'h0000;
        {can, lin1, lin2} = {OK, OK, OK};
        mode = bfws_pkg::CAN_NORMAL;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int a = 'h44; a < 'h48; a++) rdc(7'(a), 8'h00);
        rdc(7'h48, 8'h40);
        rdc(7'h49, 8'h00);
        chk({5'h00, can_en, l1_en, l2_en}, 8'h07);
        for (int k = 1; k < 4; k++) begin
            f = (k == 1) ? 6'h26 : (k == 2) ? 6'h12 : 6'h0C;
            @(posedge i_clk);
            {can, lin1, lin2} <= {f, f, f};
            @(posedge i_clk);
            {can, lin1, lin2} <= {OK, OK, OK};
            @(negedge i_clk);
            chk({5'h00, can_en, l1_en, l2_en}, 8'h00);
            rdc(7'h44, {1'b0, 2'(k), 2'h0, 2'(k), 1'b0});
            rdc(7'h45, {5'h00, 2'(k), 1'b0});
            repeat (5) @(posedge i_clk);
            @(negedge i_clk);
            chk({5'h00, can_en, l1_en, l2_en}, 8'h07);
            u_bfws_host.access(7'h44, 1'b1, d);
            u_bfws_host.access(7'h45, 1'b1, d);
        end
        chk({7'h00, tsd}, 8'h01);
        for (int m = 0; m < 5; m++) begin
            @(posedge i_clk);
            uv <= 1'b1;
            wup <= (m == 4);
            mode <= bfws_pkg::bfws_can_mode_t'((m == 4) ? 2 : m);
            u_bfws_host.access(7'h44, 1'b1, d);
            rdc(7'h44, {7'h00, m == 1 || m > 2});
            if (m == 1) chk({7'h00, can_en}, 8'h00);
        end
        @(posedge i_clk);
        {uv, wup} <= 2'b00;
        mode <= bfws_pkg::CAN_NORMAL;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        chk({7'h00, can_en}, 8'h01);
        u_bfws_host.access(7'h44, 1'b1, d);
        rdc(7'h44, 8'h00);
        @(posedge i_clk);
        wk <= 6'h3F;
        @(posedge i_clk);
        wk <= 6'h00;
        rdc(7'h46, 8'hB1);
        rdc(7'h47, 8'h03);
        u_bfws_host.access(7'h46, 1'b1, d);
        rdc(7'h46, 8'h00);
        rdc(7'h47, 8'h03);
        @(posedge i_clk);
        {dev, hvl, cfg} <= 3'b111;
        repeat (3) @(posedge i_clk);
        rdc(7'h48, 8'hE1);
        @(posedge i_clk);
        lin2 <= 6'h0C;
        @(posedge i_clk);
        lin2 <= OK;
        {i_rstn, rst_kind} <= 2'b01;
        @(posedge i_clk);
        {i_rstn, rst_kind} <= 2'b10;
        rdc(7'h45, 8'h06);
        rdc(7'h47, 8'h00);
        close_out();
    end
endmodule : bfws_status_tb_top
`default_nettype wire
